// file: verilog/vtd_top.sv
`timescale 1ns/100ps
`include "vtd_map.svh"

module vtd_top
    import vtd_pkg::*;
#(
    parameter int CHECK_STEP_CYCLES = `VTD_CHECK_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // duty input pin from the host
    input wire logic duty_voltage_input,
    // register command port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // filter side
    input wire logic [15:0] floor_voltage_code,
    input wire logic [15:0] first_filter_out,
    input wire logic [15:0] second_filter_in,
    // results
    output logic [15:0] output_reference,
    output logic [15:0] target_voltage_code,
    output logic [15:0] measured_high_time,
    output logic ref_from_first,
    output logic transition_down,
    output logic transition_up,
    output logic direction_down,
    output logic direction_up
);

    function automatic logic [16:0] ext(input logic [15:0] w);
        ext = {1'b0, w};
    endfunction

    logic sync_a;
    logic sync_b;
    logic pin_prev;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] gain_reg;
    logic [15:0] high_cnt;
    logic [15:0] prev_high_time;
    logic sample_new;
    logic [15:0] hyst_out;
    logic [23:0] hold_timer;
    vtd_state_t state;

    logic [15:0] next_rdata, next_ctrl1, next_ctrl2, next_gain, next_high_cnt, next_measured, next_prev;
    logic next_sample;
    logic [15:0] next_hyst, next_ref, next_target;
    logic [23:0] next_timer;
    vtd_state_t next_state;
    logic next_dir_down, next_dir_up;
    logic [26:0] prod;
    logic [17:0] tsum;
    logic [23:0] check_limit;
    logic [16:0] diff_band;
    logic start_down, start_up;

    always_comb begin
        next_rdata = 16'h0000;
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_gain = gain_reg;
        if (reg_wr) begin
            if (reg_addr == `VTD_ADDR_CTRL1) begin
                next_ctrl1 = reg_wdata;
            end else if (reg_addr == `VTD_ADDR_CTRL2) begin
                next_ctrl2 = reg_wdata;
            end else if (reg_addr == `VTD_ADDR_GAIN) begin
                next_gain = reg_wdata & `VTD_GAIN_MASK;
            end
        end
        if (reg_rd) begin
            if (reg_addr == `VTD_ADDR_CTRL1) begin
                next_rdata = ctrl1;
            end else if (reg_addr == `VTD_ADDR_CTRL2) begin
                next_rdata = ctrl2;
            end else if (reg_addr == `VTD_ADDR_GAIN) begin
                next_rdata = gain_reg & `VTD_GAIN_MASK;
            end
        end

        // each clock high adds one 25 ns period in 5 ns units
        next_high_cnt = high_cnt;
        next_measured = measured_high_time;
        next_prev = prev_high_time;
        next_sample = 1'b0;
        if (sync_b && !pin_prev) begin
            next_high_cnt = 16'(`VTD_ONTIME_STEP);
        end else if (sync_b && high_cnt < 16'(16'hffff - `VTD_ONTIME_STEP)) begin
            next_high_cnt = high_cnt + 16'(`VTD_ONTIME_STEP);
        end else if (!sync_b && pin_prev) begin
            next_measured = high_cnt;
            next_prev = measured_high_time;
            next_sample = 1'b1;
        end

        prod = 27'(measured_high_time) * 27'(gain_reg[10:0]);
        tsum = prod[26:`VTD_GAIN_SHIFT] + 18'(floor_voltage_code);
        next_target = tsum[15:0];

        // hysteresis stage on the second filter
        next_hyst = hyst_out;
        next_timer = hold_timer;
        check_limit = 24'(ctrl1[`VTD_CHECK_HI:`VTD_CHECK_LO]) * 24'(CHECK_STEP_CYCLES);
        diff_band = (second_filter_in > hyst_out) ? ext(second_filter_in) - ext(hyst_out)
                                                  : ext(hyst_out) - ext(second_filter_in);
        if (diff_band > ext(`VTD_HYST_BAND)) begin
            next_hyst = second_filter_in;
            next_timer = 24'h000000;
        end else if (ctrl2[`VTD_SYNC_BIT] && check_limit != 24'h000000 && hold_timer + 24'h000001 >= check_limit) begin
            next_hyst = second_filter_in;
            next_timer = 24'h000000;
        end else begin
            next_timer = (hold_timer < check_limit) ? hold_timer + 24'h000001 : check_limit;
        end

        // transition start conditions
        if (ctrl2[`VTD_TRIG_BIT]) begin
            start_down = sample_new && ext(prev_high_time) > ext(measured_high_time)
                + 17'(ctrl2[`VTD_FALL_HI:`VTD_FALL_LO]);
            start_up = sample_new && ext(measured_high_time) > ext(prev_high_time)
                + 17'(ctrl2[`VTD_RISE_HI:`VTD_RISE_LO]);
        end else begin // the registered reference lags state by a cycle, so compare with its settled source
            start_down = ext(target_voltage_code) + 17'(ctrl1[`VTD_DSTART_HI:`VTD_DSTART_LO])
                < ext(hyst_out);
            start_up = ext(target_voltage_code) > ext(hyst_out)
                + 17'(ctrl1[`VTD_USTART_HI:`VTD_USTART_LO]);
        end

        next_state = state;
        case (state)
            VTD_SETTLED: begin
                if (start_down) begin
                    next_state = VTD_DOWN;
                end else if (start_up) begin
                    next_state = VTD_UP;
                end
            end
            VTD_DOWN: begin
                if (ext(output_reference) < ext(target_voltage_code)
                    + 17'(ctrl1[`VTD_DEND_HI:`VTD_DEND_LO])) begin
                    next_state = VTD_SETTLED;
                end
            end
            VTD_UP: begin
                // no end margin exists for upward moves; end once the first filter reference reaches target
                if (ref_from_first && output_reference >= target_voltage_code) begin
                    next_state = VTD_SETTLED;
                end
            end
            default: begin
                next_state = VTD_SETTLED;
            end
        endcase

        next_ref = (state == VTD_SETTLED) ? hyst_out : first_filter_out;
        next_dir_down = ext(output_reference) > ext(target_voltage_code)
            + 17'(ctrl2[`VTD_DOWN_DIR_HI:`VTD_DOWN_DIR_LO]);
        next_dir_up = ext(output_reference) + 17'(ctrl2[`VTD_UP_DIR_HI:`VTD_UP_DIR_LO])
            < ext(target_voltage_code);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            pin_prev <= 1'b0;
            ctrl1 <= `VTD_CTRL1_RESET;
            ctrl2 <= `VTD_CTRL2_RESET;
            gain_reg <= `VTD_GAIN_RESET;
            reg_rdata <= 16'h0000;
            high_cnt <= 16'h0000;
            measured_high_time <= 16'h0000;
            prev_high_time <= 16'h0000;
            sample_new <= 1'b0;
            target_voltage_code <= 16'h0000;
            hyst_out <= 16'h0000;
            hold_timer <= 24'h000000;
            state <= VTD_SETTLED;
            output_reference <= 16'h0000;
            ref_from_first <= 1'b0;
            transition_down <= 1'b0;
            transition_up <= 1'b0;
            direction_down <= 1'b0;
            direction_up <= 1'b0;
        end else begin
            sync_a <= duty_voltage_input;
            sync_b <= sync_a;
            pin_prev <= sync_b;
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            gain_reg <= next_gain;
            reg_rdata <= next_rdata;
            high_cnt <= next_high_cnt;
            measured_high_time <= next_measured;
            prev_high_time <= next_prev;
            sample_new <= next_sample;
            target_voltage_code <= next_target;
            hyst_out <= next_hyst;
            hold_timer <= next_timer;
            state <= next_state;
            output_reference <= next_ref;
            ref_from_first <= (state != VTD_SETTLED);
            transition_down <= (next_state == VTD_DOWN);
            transition_up <= (next_state == VTD_UP);
            direction_down <= next_dir_down;
            direction_up <= next_dir_up;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_gain_rsvd_zero;
        reg_rd && reg_addr == `VTD_ADDR_GAIN |=> reg_rdata[15:11] == 5'h00;
    endproperty
    a_gain_rsvd_zero: assert property (p_gain_rsvd_zero) else $error("gain reserved bits not zero");
    property p_target_calc;
        $changed(measured_high_time) && $stable(gain_reg) && $stable(floor_voltage_code) |=>
            target_voltage_code == 16'((27'($past(measured_high_time)) * 27'(gain_reg[10:0])) >> 9)
            + floor_voltage_code;
    endproperty
    a_target_calc: assert property (p_target_calc) else $error("target code wrong");
    property p_settled_ref;
        state == VTD_SETTLED |=> output_reference == $past(hyst_out) && !ref_from_first;
    endproperty
    a_settled_ref: assert property (p_settled_ref) else $error("settled reference not from second filter");
    property p_fall_start;
        state == VTD_SETTLED && ctrl2[15] && sample_new
            && prev_high_time > measured_high_time + 16'(ctrl2[5:3]) |=> state == VTD_DOWN ##1 ref_from_first;
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("on-time fall missed");
    property p_rise_start;
        state == VTD_SETTLED && ctrl2[15] && sample_new && !(prev_high_time > measured_high_time)
            && measured_high_time > prev_high_time + 16'(ctrl2[2:0]) |=> state == VTD_UP;
    endproperty
    a_rise_start: assert property (p_rise_start) else $error("on-time rise missed");
    property p_cmp_start;
        state == VTD_SETTLED && !ctrl2[15]
            && ext(target_voltage_code) + 17'(ctrl1[15:13]) < ext(hyst_out) |=> transition_down;
    endproperty
    a_cmp_start: assert property (p_cmp_start) else $error("compare down start missed");
    property p_down_end;
        state == VTD_DOWN && ext(output_reference) < ext(target_voltage_code) + 17'(ctrl1[9:7])
            |=> state == VTD_SETTLED;
    endproperty
    a_down_end: assert property (p_down_end) else $error("down transition did not end");
    property p_dir_down;
        ##1 direction_down == ($past(ext(output_reference)) > $past(ext(target_voltage_code)) + 17'($past(ctrl2[13:10])));
    endproperty
    a_dir_down: assert property (p_dir_down) else $error("down direction wrong");
    property p_dir_up;
        direction_up |-> $past(ext(output_reference)) + 17'($past(ctrl2[9:6])) < $past(ext(target_voltage_code));
    endproperty
    a_dir_up: assert property (p_dir_up) else $error("up direction wrong");
    property p_hyst_hold;
        !ctrl2[14] && diff_band <= 17'(`VTD_HYST_BAND) |=> $stable(hyst_out);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis moved without cause");
    property p_timer_bound;
        hold_timer <= check_limit;
    endproperty
    a_timer_bound: assert property (p_timer_bound) else $error("check timer overran");
    property p_high_units;
        sample_new |-> measured_high_time % 16'(`VTD_ONTIME_STEP) == 16'h0000;
    endproperty
    a_high_units: assert property (p_high_units) else $error("high time not in clock steps");

endmodule

// file: verilog/vtd_map.svh
`ifndef VTD_MAP_SVH
`define VTD_MAP_SVH

// command codes of the three filter registers
`define VTD_ADDR_CTRL1 8'hb1
`define VTD_ADDR_CTRL2 8'hb2
`define VTD_ADDR_GAIN 8'hb3

`define VTD_CTRL1_RESET 16'h0000
`define VTD_CTRL2_RESET 16'h0000
`define VTD_GAIN_RESET 16'h0000
`define VTD_GAIN_MASK 16'h07ff

// second filter control fields
`define VTD_TRIG_BIT 15
`define VTD_SYNC_BIT 14
`define VTD_DOWN_DIR_HI 13
`define VTD_DOWN_DIR_LO 10
`define VTD_UP_DIR_HI 9
`define VTD_UP_DIR_LO 6
`define VTD_FALL_HI 5
`define VTD_FALL_LO 3
`define VTD_RISE_HI 2
`define VTD_RISE_LO 0

// first filter control fields
`define VTD_DSTART_HI 15
`define VTD_DSTART_LO 13
`define VTD_USTART_HI 12
`define VTD_USTART_LO 10
`define VTD_DEND_HI 9
`define VTD_DEND_LO 7
`define VTD_CHECK_HI 6
`define VTD_CHECK_LO 2

// timing
`define VTD_CLK_MHZ 40
`define VTD_CLK_PERIOD_NS 25
`define VTD_ONTIME_LSB_NS 5
`define VTD_ONTIME_STEP (`VTD_CLK_PERIOD_NS / `VTD_ONTIME_LSB_NS)
`define VTD_CHECK_STEP_US 100
`define VTD_CHECK_STEP_CYCLES (`VTD_CHECK_STEP_US * `VTD_CLK_MHZ)
`define VTD_GAIN_SHIFT 9
`define VTD_HYST_BAND 16'h0002

`endif

// file: verilog/vtd_pkg.sv
package vtd_pkg;
    typedef enum logic [1:0] {VTD_SETTLED, VTD_DOWN, VTD_UP} vtd_state_t;
    typedef logic [15:0] vtd_word_t;
endpackage

// file: test/vtd_duty_host.sv
`timescale 1ns/100ps
module vtd_duty_host
    import vtd_pkg::*;
(
    // clock
    input wire logic clk,
    // duty pin toward the device
    output logic duty_out
);
    initial duty_out = 1'b0;

    // pin idles low between pulses; edges land on falling clock edges
    task automatic pulse(input int high_clks);
        @(negedge clk);
        duty_out = 1'b1;
        repeat (high_clks) @(negedge clk);
        duty_out = 1'b0;
        // room for sync, sample, target, start check and reference switch
        repeat (12) @(negedge clk);
    endtask
endmodule

// file: test/test_vid_transition_detect_target.sv
`timescale 1ns/100ps
`include "vtd_map.svh"
`define CHK(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("unexpected %s exp=%h got=%h", what, exp, got); \
        end \
    end

module test_vid_transition_detect_target
    import vtd_pkg::*;
;
    logic clk, rst_n, duty, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, floor_code, first_out, second_in;
    logic [15:0] out_ref, target, high_time;
    logic from_first, tr_down, tr_up, dir_down, dir_up;
    int n_errors = 0;
    int checks = 0;

    vtd_top #(.CHECK_STEP_CYCLES(4)) dut_u (
        .clk(clk), .rst_n(rst_n), .duty_voltage_input(duty),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .floor_voltage_code(floor_code), .first_filter_out(first_out),
        .second_filter_in(second_in), .output_reference(out_ref),
        .target_voltage_code(target), .measured_high_time(high_time),
        .ref_from_first(from_first), .transition_down(tr_down),
        .transition_up(tr_up), .direction_down(dir_down), .direction_up(dir_up)
    );

    vtd_duty_host host_u (.clk(clk), .duty_out(duty));

    task automatic conclude();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // read data stands for one cycle only, so it is taken at the next low phase
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK("register read", e, reg_rdata)
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        floor_code = 16'h0064;
        first_out = 16'h0050;
        // equal to the floor target so compare mode stays quiet after reset
        second_in = 16'h0064;
        idle(12);
        rst_n = 1'b1;
        rdchk(`VTD_ADDR_CTRL1, 16'h0000);
        rdchk(`VTD_ADDR_CTRL2, 16'h0000);
        rdchk(`VTD_ADDR_GAIN, 16'h0000);
        rdchk(8'hb4, 16'h0000);
        wr(`VTD_ADDR_GAIN, 16'hffff);
        rdchk(`VTD_ADDR_GAIN, 16'h07ff);
        // unity gain: code span equal to the high time in 5 ns steps
        wr(`VTD_ADDR_GAIN, 16'h0200);
        wr(`VTD_ADDR_CTRL2, 16'h8cd2);
        rdchk(`VTD_ADDR_CTRL2, 16'h8cd2);
        second_in = 16'h0400;
        idle(4);
        `CHK("output_reference", 16'h0400, out_ref)
        host_u.pulse(20);
        `CHK("measured_high_time", 16'h0064, high_time)
        `CHK("target_voltage_code", 16'h00c8, target)
        `CHK("transition_up", 1'b1, tr_up)
        `CHK("ref_from_first", 1'b1, from_first)
        `CHK("output_reference", 16'h0050, out_ref)
        `CHK("direction_up", 1'b1, dir_up)
        first_out = 16'h0100;
        idle(4);
        `CHK("transition_up", 1'b0, tr_up)
        `CHK("output_reference", 16'h0400, out_ref)
        `CHK("direction_down", 1'b1, dir_down)
        host_u.pulse(19);
        `CHK("transition_down", 1'b1, tr_down)
        `CHK("output_reference", 16'h0100, out_ref)
        first_out = 16'h0080;
        idle(4);
        `CHK("transition_down", 1'b0, tr_down)
        // a change equal to the threshold must not start a transition
        wr(`VTD_ADDR_CTRL2, 16'h8cd5);
        host_u.pulse(20);
        `CHK("transition_up", 1'b0, tr_up)
        wr(`VTD_ADDR_CTRL1, 16'h488c);
        first_out = 16'h0300;
        wr(`VTD_ADDR_CTRL2, 16'h0cd5);
        idle(4);
        `CHK("transition_down", 1'b1, tr_down)
        `CHK("output_reference", 16'h0300, out_ref)
        second_in = 16'h00c9;
        first_out = 16'h00c0;
        idle(4);
        `CHK("transition_down", 1'b0, tr_down)
        `CHK("output_reference", 16'h00c9, out_ref)
        second_in = 16'h00ca;
        idle(40);
        `CHK("output_reference", 16'h00c9, out_ref)
        wr(`VTD_ADDR_CTRL2, 16'h4cd5);
        idle(40);
        `CHK("output_reference", 16'h00ca, out_ref)
        conclude();
    end
endmodule
